// ### design/dpc_pkg.sv
// Package with register map, field positions and reset values of the PLL configuration bank.
`default_nettype none
package dpc_pkg;
   localparam logic [11:0] ADDR_PD_A      = 12'h790;
   localparam logic [11:0] ADDR_PD_B      = 12'h791;
   localparam logic [11:0] ADDR_RST_CTRL  = 12'h792;
   localparam logic [11:0] ADDR_PREDIV    = 12'h793;
   localparam logic [11:0] ADDR_PUMP      = 12'h794;
   localparam logic [11:0] ADDR_TUNE_A    = 12'h795;
   localparam logic [11:0] ADDR_TUNE_B    = 12'h796;
   localparam logic [11:0] ADDR_TUNE_C    = 12'h797;
   localparam logic [11:0] ADDR_TUNE_D    = 12'h798;
   localparam logic [11:0] ADDR_DIV       = 12'h799;
   localparam logic [11:0] ADDR_VARACTOR  = 12'h7A0;
   localparam logic [11:0] ADDR_CAL_TIME  = 12'h7A2;
   localparam logic [11:0] ADDR_LOCK      = 12'h7B5;

   // Reset values of whole registers, reserved bits included.
   localparam logic [7:0] RST_PD_A     = 8'h02;
   localparam logic [7:0] RST_PD_B     = 8'h00;
   localparam logic [7:0] RST_RST_CTRL = 8'h02;
   localparam logic [7:0] RST_PREDIV   = 8'h00;
   localparam logic [7:0] RST_PUMP     = 8'h04;
   localparam logic [7:0] RST_TUNE_A   = 8'h08;
   localparam logic [7:0] RST_TUNE_B   = 8'hD2;
   localparam logic [7:0] RST_TUNE_C   = 8'h20;
   localparam logic [7:0] RST_TUNE_D   = 8'h1C;
   localparam logic [7:0] RST_DIV      = 8'h08;
   localparam logic [7:0] RST_VARACTOR = 8'h90;
   localparam logic [7:0] RST_CAL_TIME = 8'h35;

   // Writable masks; cleared bits are read-only reserved bits.
   localparam logic [7:0] WM_RST_CTRL  = 8'h03;
   localparam logic [7:0] WM_PREDIV    = 8'h03;
   localparam logic [7:0] WM_TUNE_D    = 8'h7F;
   localparam logic [7:0] WM_CAL_TIME  = 8'h7F;

   // Field positions.
   localparam int BIT_PD_ONE       = 1;
   localparam int BIT_CAL_HOLD     = 1;
   localparam int BIT_VCO_DIV_HOLD = 0;
   localparam int BIT_LOCK         = 0;
   localparam int LSB_ADC_DIV      = 6;

   // Feedback divider legal range.
   localparam logic [5:0] N_DIV_MIN = 6'h02;
   localparam logic [5:0] N_DIV_MAX = 6'h32;

   typedef enum logic [1:0] {DPC_DIV1, DPC_DIV2, DPC_DIV3, DPC_DIV4} dpc_div_t;
endpackage
`default_nettype wire

// ### design/dpc_clk_div_if.sv
// Interface between the bank and its observation clock divider.
`default_nettype none
interface dpc_clk_div_if;
   logic       hold;
   logic [1:0] ratio;
   logic       clk_en;
   modport ctrl (output hold, output ratio, input clk_en);
   modport div  (input hold, input ratio, output clk_en);
endinterface
`default_nettype wire

// ### design/dpc_adc_clk_div.sv
// Divider producing the observation ADC clock enable from the multiplier output.
`default_nettype none
module dpc_adc_clk_div
   import dpc_pkg::*;
(
   // Clock and reset.
   input  wire logic  core_clk,
   input  wire logic  srst,
   // Control and enable.
   dpc_clk_div_if.div dif
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       en_q;
   logic       en_d;

   always_comb begin
      cnt_d = cnt_q;
      en_d  = 1'b0;
      if (dif.hold) begin
         cnt_d = 2'h0;
      end else if (cnt_q >= dif.ratio) begin
         cnt_d = 2'h0;
         en_d  = 1'b1;
      end else begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q <= 2'h0;
         en_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         en_q  <= en_d;
      end
   end

   assign dif.clk_en = en_q;
endmodule
`default_nettype wire

// ### design/dpc_config_bank.sv
// Register bank for the clock multiplier PLL configuration and lock status.
// How it works
// [RL1] Software sets every power-down bit when the multiplier is bypassed.
// [RL2] Power-down bit one resets to 1; software clears it to use the PLL.
// [RL3] Divider hold bit keeps output divider reset, stopping the ADC clock driver.
// [RL4] Two-bit predivider holds ratio minus one, dividing reference by 1 to 4.
// [RL5] Software picks predivider keeping phase detector frequency in its allowed range.
// [RL6] Six-bit pump code sets current 100 uA plus 100 uA per step; resets 4.
// [RL7] Two-bit ADC clock divider code selects divide by 1 to 4; resets 0.
// [RL8] Feedback divider accepts 2 to 50 and resets to 8.
// [RL9] Status bit 0 is a read-only lock flag, zero after reset.
// [RL10] Calibration reset bit comes out of reset set, holding calibration.
// [RL11] Tuning fields and calibration timing fields take their documented reset values.
// [RL12] Lock flag follows the live detector; status and reserved writes are ignored.
`default_nettype none
module dpc_config_bank
   import dpc_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Register port.
   input  wire logic [11:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output var  logic [7:0]  reg_rdata,
   // Analog side.
   input  wire logic        pll_locked,
   output var  logic [12:0] powerdown_bits,
   output var  logic        cal_hold,
   output var  logic        vco_output_divider_hold,
   output var  logic [1:0]  predivider_code,
   output var  logic [5:0]  pump_current_code,
   output var  logic [5:0]  feedback_divider,
   output var  logic        adc_clk_en
);
   typedef enum logic [3:0] {
      R_PD_A, R_PD_B, R_RST, R_PREDIV, R_PUMP, R_TA, R_TB, R_TC, R_TD, R_DIV,
      R_VAR, R_CAL, R_LOCK, R_NONE
   } dpc_reg_t;

   function automatic dpc_reg_t decode(input logic [11:0] a);
      if (a == ADDR_PD_A) begin
         decode = R_PD_A;
      end else if (a == ADDR_PD_B) begin
         decode = R_PD_B;
      end else if (a == ADDR_RST_CTRL) begin
         decode = R_RST;
      end else if (a == ADDR_PREDIV) begin
         decode = R_PREDIV;
      end else if (a == ADDR_PUMP) begin
         decode = R_PUMP;
      end else if (a == ADDR_TUNE_A) begin
         decode = R_TA;
      end else if (a == ADDR_TUNE_B) begin
         decode = R_TB;
      end else if (a == ADDR_TUNE_C) begin
         decode = R_TC;
      end else if (a == ADDR_TUNE_D) begin
         decode = R_TD;
      end else if (a == ADDR_DIV) begin
         decode = R_DIV;
      end else if (a == ADDR_VARACTOR) begin
         decode = R_VAR;
      end else if (a == ADDR_CAL_TIME) begin
         decode = R_CAL;
      end else if (a == ADDR_LOCK) begin
         decode = R_LOCK;
      end else begin
         decode = R_NONE;
      end
   endfunction

   // Stored register images, one byte per mapped address except the lock status, held as one bit.
   logic [7:0] pd_a_q;
   logic [7:0] pd_a_d;
   logic [7:0] pd_b_q;
   logic [7:0] pd_b_d;
   logic [7:0] rst_q;
   logic [7:0] rst_d;
   logic [7:0] prediv_q;
   logic [7:0] prediv_d;
   logic [7:0] pump_q;
   logic [7:0] pump_d;
   logic [7:0] ta_q;
   logic [7:0] ta_d;
   logic [7:0] tb_q;
   logic [7:0] tb_d;
   logic [7:0] tc_q;
   logic [7:0] tc_d;
   logic [7:0] td_q;
   logic [7:0] td_d;
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic [7:0] var_q;
   logic [7:0] var_d;
   logic [7:0] cal_q;
   logic [7:0] cal_d;
   logic       lock_q;
   logic       lock_d;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // Decoder results and the feedback value under test.
   dpc_reg_t   wsel;
   dpc_reg_t   rsel;
   logic [5:0] n_in;
   logic       n_ok;

   // The divider sees only the hold bit and the ratio field.
   dpc_clk_div_if dif ();

   // Write side: a register keeps its value unless a write selects it.
   always_comb begin
      wsel     = decode(reg_addr);
      n_in     = reg_wdata[5:0];
      n_ok     = (n_in >= N_DIV_MIN) && (n_in <= N_DIV_MAX); // [RL8]
      pd_a_d   = pd_a_q;
      pd_b_d   = pd_b_q;
      rst_d    = rst_q;
      prediv_d = prediv_q;
      pump_d   = pump_q;
      ta_d     = ta_q;
      tb_d     = tb_q;
      tc_d     = tc_q;
      td_d     = td_q;
      div_d    = div_q;
      var_d    = var_q;
      cal_d    = cal_q;
      if (reg_wr) begin
         case (wsel)
            R_PD_A: begin
               pd_a_d = reg_wdata; // [RL1] [RL2]
            end
            R_PD_B: begin
               pd_b_d = reg_wdata; // [RL1]
            end
            R_RST: begin
               rst_d = reg_wdata & WM_RST_CTRL; // [RL3] [RL10] [RL12]
            end
            R_PREDIV: begin
               prediv_d = reg_wdata & WM_PREDIV; // [RL4] [RL12]
            end
            R_PUMP: begin
               pump_d = reg_wdata; // [RL6]
            end
            R_TA: begin
               ta_d = reg_wdata; // [RL11]
            end
            R_TB: begin
               tb_d = reg_wdata; // [RL11]
            end
            R_TC: begin
               tc_d = reg_wdata; // [RL11]
            end
            R_TD: begin
               td_d = reg_wdata & WM_TUNE_D; // [RL11] [RL12]
            end
            R_DIV: begin
               // Out-of-range feedback values are refused; the ADC field still updates.
               if (n_ok) begin // [RL8]
                  div_d = reg_wdata; // [RL7]
               end else begin
                  div_d = {reg_wdata[7:6], div_q[5:0]}; // [RL7]
               end
            end
            R_VAR: begin
               var_d = reg_wdata;
            end
            R_CAL: begin
               cal_d = reg_wdata & WM_CAL_TIME; // [RL11] [RL12]
            end
            default: begin
            end
         endcase
      end
   end

   // Reserved read-write bits keep what was written; reset restores every field.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pd_a_q   <= RST_PD_A; // [RL2]
         pd_b_q   <= RST_PD_B;
         rst_q    <= RST_RST_CTRL; // [RL10]
         prediv_q <= RST_PREDIV;
         pump_q   <= RST_PUMP; // [RL6]
         ta_q     <= RST_TUNE_A; // [RL11]
         tb_q     <= RST_TUNE_B; // [RL11]
         tc_q     <= RST_TUNE_C; // [RL11]
         td_q     <= RST_TUNE_D; // [RL11]
         div_q    <= RST_DIV; // [RL7] [RL8]
         var_q    <= RST_VARACTOR;
         cal_q    <= RST_CAL_TIME; // [RL11]
      end else begin
         pd_a_q   <= pd_a_d;
         pd_b_q   <= pd_b_d;
         rst_q    <= rst_d;
         prediv_q <= prediv_d;
         pump_q   <= pump_d;
         ta_q     <= ta_d;
         tb_q     <= tb_d;
         tc_q     <= tc_d;
         td_q     <= td_d;
         div_q    <= div_d;
         var_q    <= var_d;
         cal_q    <= cal_d;
      end
   end

   // Status side: the lock flag follows the detector one cycle late, never latched.
   always_comb begin
      lock_d = pll_locked; // [RL12]
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         lock_q <= 1'b0; // [RL9]
      end else begin
         lock_q <= lock_d;
      end
   end

   // Read side: the data register holds the last read until the next read strobe.
   always_comb begin
      rsel    = decode(reg_addr);
      rdata_d = rdata_q;
      if (reg_rd) begin
         case (rsel)
            R_PD_A: begin
               rdata_d = pd_a_q;
            end
            R_PD_B: begin
               rdata_d = pd_b_q;
            end
            R_RST: begin
               rdata_d = rst_q;
            end
            R_PREDIV: begin
               rdata_d = prediv_q;
            end
            R_PUMP: begin
               rdata_d = pump_q;
            end
            R_TA: begin
               rdata_d = ta_q;
            end
            R_TB: begin
               rdata_d = tb_q;
            end
            R_TC: begin
               rdata_d = tc_q;
            end
            R_TD: begin
               rdata_d = td_q;
            end
            R_DIV: begin
               rdata_d = div_q;
            end
            R_VAR: begin
               rdata_d = var_q;
            end
            R_CAL: begin
               rdata_d = cal_q;
            end
            R_LOCK: begin
               rdata_d = {7'h00, lock_q}; // [RL9]
            end
            default: begin
               // Unmapped addresses read as zero.
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign dif.hold  = rst_q[BIT_VCO_DIV_HOLD]; // [RL3]
   assign dif.ratio = div_q[LSB_ADC_DIV +: 2]; // [RL7]

   dpc_adc_clk_div u_div (
      .core_clk (core_clk),
      .srst     (srst),
      .dif      (dif.div)
   );

   assign reg_rdata               = rdata_q;
   assign powerdown_bits          = {pd_b_q[4:0], pd_a_q[7:2], pd_a_q[BIT_PD_ONE], pd_a_q[0]};
   assign cal_hold                = rst_q[BIT_CAL_HOLD];
   assign vco_output_divider_hold = rst_q[BIT_VCO_DIV_HOLD];
   assign predivider_code         = prediv_q[1:0]; // [RL4]
   assign pump_current_code       = pump_q[5:0]; // [RL6]
   assign feedback_divider        = div_q[5:0];
   assign adc_clk_en              = dif.clk_en; // [RL3]
endmodule
`default_nettype wire

// ### tb/dpc_lock_model.sv
// Behavioural lock detector of the clock multiplier.
`default_nettype none
module dpc_lock_model #(
   parameter int LOCK_CYC = 6
) (
   input  wire logic core_clk,
   input  wire logic want_lock,
   output var  logic pll_locked
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial pll_locked = 1'b0;
   // Lock is gained slowly but lost at once, as a real loop does.
   always @(posedge core_clk) begin
      cnt <= want_lock ? cnt + 1 : 0;
      pll_locked <= want_lock && cnt >= LOCK_CYC;
   end
endmodule
`default_nettype wire

// ### tb/dpc_config_bank_assertions.sv
// Port checks of the PLL configuration bank.
`default_nettype none
module dpc_config_bank_assertions
   import dpc_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        pll_locked,
   input wire logic [12:0] powerdown_bits,
   input wire logic        cal_hold,
   input wire logic        vco_output_divider_hold,
   input wire logic [1:0]  predivider_code,
   input wire logic [5:0]  pump_current_code,
   input wire logic [5:0]  feedback_divider,
   input wire logic        adc_clk_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [1:0] ratio_q;
   logic [1:0] ratio_d;
   always_comb begin
      ratio_d = ratio_q;
      if (reg_wr && reg_addr == ADDR_DIV)
         ratio_d = reg_wdata[7:6];
   end
   always_ff @(posedge core_clk)
      ratio_q <= srst ? 2'h0 : ratio_d;
   sequence s_bad_n;
      reg_wr && reg_addr == ADDR_DIV && !(reg_wdata[5:0] inside {[N_DIV_MIN:N_DIV_MAX]});
   endsequence
   sequence s_slow_pulse;
      adc_clk_en && ratio_q == 2'h3 && !reg_wr;
   endsequence
   a_reset_vals: assert property ($fell(srst) |-> cal_hold && powerdown_bits[1] &&
      pump_current_code == 6'h04 && feedback_divider == 6'h08) else $error("reset value");
   a_pump_write: assert property (reg_wr && reg_addr == ADDR_PUMP |=>
      pump_current_code == $past(reg_wdata[5:0])) else $error("pump code");
   a_prediv_write: assert property (reg_wr && reg_addr == ADDR_PREDIV |=>
      predivider_code == $past(reg_wdata[1:0])) else $error("predivider");
   a_hold_write: assert property (reg_wr && reg_addr == ADDR_RST_CTRL |=>
      {cal_hold, vco_output_divider_hold} == $past(reg_wdata[1:0])) else $error("hold bits");
   a_pd_write: assert property (reg_wr && reg_addr == ADDR_PD_A |=>
      powerdown_bits[1:0] == $past(reg_wdata[1:0])) else $error("power-down");
   a_bad_n_kept: assert property (s_bad_n |=> $stable(feedback_divider))
      else $error("divider changed");
   a_n_range: assert property (feedback_divider inside {[N_DIV_MIN:N_DIV_MAX]})
      else $error("divider range");
   a_hold_stops: assert property (vco_output_divider_hold && $past(vco_output_divider_hold)
      |-> !adc_clk_en) else $error("clock not held");
   a_div4_gap: assert property (s_slow_pulse |=> !adc_clk_en ##1
      (!adc_clk_en || $past(ratio_q) != 2'h3) ##1
      (!adc_clk_en || $past(ratio_q) != 2'h3 || $past(ratio_q, 2) != 2'h3))
      else $error("pulse gap");
   a_lock_read: assert property (reg_rd && reg_addr == ADDR_LOCK && $stable(pll_locked)
      |=> reg_rdata == {7'h00, $past(pll_locked, 2)}) else $error("lock read");
endmodule
bind dpc_config_bank dpc_config_bank_assertions dpc_config_bank_assertions_i (.*);
`default_nettype wire

// ### tb/tb_dpc_config_bank.sv
// Self-checking bench of the PLL configuration bank.
`default_nettype none
module tb_dpc_config_bank
   import dpc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, want_lock = 0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, dat, d;
   logic        pll_locked, cal_hold, vco_output_divider_hold, adc_clk_en;
   logic [12:0] powerdown_bits;
   logic [1:0]  predivider_code;
   logic [5:0]  pump_current_code, feedback_divider, n_q;
   int          fails = 0, n_compared = 0, pulses, i;
   logic [11:0] ra [14] = '{ADDR_PD_A, ADDR_PD_B, ADDR_RST_CTRL, ADDR_PREDIV, ADDR_PUMP,
      ADDR_TUNE_A, ADDR_TUNE_B, ADDR_TUNE_C, ADDR_TUNE_D, ADDR_DIV, ADDR_VARACTOR,
      ADDR_CAL_TIME, ADDR_LOCK, 12'h7A1};
   logic [7:0]  rv [14] = '{RST_PD_A, RST_PD_B, RST_RST_CTRL, RST_PREDIV, RST_PUMP,
      RST_TUNE_A, RST_TUNE_B, RST_TUNE_C, RST_TUNE_D, RST_DIV, RST_VARACTOR,
      RST_CAL_TIME, 8'h00, 8'h00};
   logic [5:0]  nv [7] = '{6'h01, 6'h02, 6'h32, 6'h33, 6'h00, 6'h3F, 6'h08};
   always #25 core_clk = ~core_clk;
   dpc_lock_model dpc_lock_model_i (.core_clk(core_clk), .want_lock(want_lock),
      .pll_locked(pll_locked));
   dpc_config_bank dpc_config_bank_i (.*);
   function automatic logic [7:0] wmask(input logic [11:0] a);
      case (a)
         ADDR_RST_CTRL: return WM_RST_CTRL;
         ADDR_PREDIV:   return WM_PREDIV;
         ADDR_TUNE_D:   return WM_TUNE_D;
         ADDR_CAL_TIME: return WM_CAL_TIME;
         default:       return 8'hFF;
      endcase
   endfunction
   function automatic logic [5:0] next_n(input logic [5:0] old, input logic [5:0] v);
      return (v >= 6'h02 && v <= 6'h32) ? v : old;
   endfunction
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(negedge core_clk);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge core_clk);
      reg_wr = 0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(negedge core_clk);
      reg_rd = 1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 0;
      dat = reg_rdata;
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #1000000;
      fails++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h18DF));
      repeat (20) @(negedge core_clk);
      srst = 0;
      for (i = 0; i < 14; i++) begin
         rd(ra[i]);
         chk(dat, rv[i]);
      end
      $display("reset values done");
      repeat (40) begin
         i = $urandom_range(0, 10);
         i = i > 8 ? i + 1 : i;
         d = 8'($urandom);
         wr(ra[i], d);
         rd(ra[i]);
         chk(dat, d & wmask(ra[i]));
      end
      $display("random access done");
      for (i = 0; i < 4; i++) begin
         wr(ADDR_PREDIV, {6'h3F, 2'(i)});
         chk(predivider_code, 13'(i));
      end
      n_q = RST_DIV[5:0];
      for (i = 0; i < 7; i++) begin
         wr(ADDR_DIV, {2'h0, nv[i]});
         n_q = next_n(n_q, nv[i]);
         chk(feedback_divider, n_q);
      end
      $display("dividers done");
      wr(ADDR_RST_CTRL, 8'h00);
      chk(cal_hold, 1'b0);
      for (i = 0; i < 4; i++) begin
         wr(ADDR_DIV, {2'(i), 6'h08});
         repeat (4) @(negedge core_clk);
         pulses = 0;
         repeat (24) @(negedge core_clk) pulses += adc_clk_en;
         chk(13'(pulses), 13'(24 / (i + 1)));
      end
      wr(ADDR_RST_CTRL, 8'h01);
      pulses = 0;
      repeat (12) @(negedge core_clk) pulses += adc_clk_en;
      chk(13'(pulses), 13'h0000);
      $display("adc clock done");
      want_lock = 1;
      repeat (12) @(negedge core_clk);
      rd(ADDR_LOCK);
      chk(dat, 8'h01);
      wr(ADDR_LOCK, 8'hFE);
      rd(ADDR_LOCK);
      chk(dat, 8'h01);
      want_lock = 0;
      repeat (3) @(negedge core_clk);
      rd(ADDR_LOCK);
      chk(dat, 8'h00);
      $display("lock done");
      wr(ADDR_PD_A, 8'hFF);
      wr(ADDR_PD_B, 8'h1F);
      chk(powerdown_bits, 13'h1FFF);
      wr(ADDR_PD_A, 8'h00);
      wr(ADDR_PD_B, 8'h00);
      chk(powerdown_bits, 13'h0000);
      $display("power-down done");
      stop_test();
   end
endmodule
`default_nettype wire
